// ===== verilog/cps_sequencer.sv
// Charger power-up sequencer with APB status and control registers
//
// How it works
// - Battery only: switch closed while battery above depletion, bias regulator off
// - Supplement overcurrent opens switch, sets off bit
// - Switch stays open until input, exit or a control write with off bit clear
// - Strict order: bias, qualify, detect, limit, converter
// - Bias on after conditions hold 220 ms
// - Qualify: no overvoltage, above minimum, 30 ms load
// - Failed qualification retried every two seconds
// - Pass sets input good and pulses interrupt
// - Detect after input good, pulse when done
// - Detect loads current limit, power good, type
// - Pin high 500 mA 001, low 2400 mA 010
// - Default mode copies pin; host needs request bit
// - Four-bit voltage limit 3.9 to 5.4 V, 4.5 default
// - Tracking 00 off, else max with battery offset
// - Converter starts after limit set, soft start while rail below 2.2 V
// - Below 2.2 V rail limit is min 200 mA
// - After start switch follows charge enable, except in boost where it stays closed
// - Outside boost, light load only if charge off or battery low
// - Boost after 30 ms enable plus entry conditions
// - Boost limit bit selects 0.5 A or 1.2 A
// - Boost reads type 111
// - Boost starts light load, then fixed frequency
// - Interrupts are active-low pulses
`timescale 1ns/100ps
module cps_sequencer
    import cps_pkg::*;
#(
    parameter int BIAS_DLY_CYC  = CPS_BIAS_DLY_MS * CPS_CLK_MHZ * 1000,
    parameter int QUAL_WIN_CYC  = CPS_QUAL_WIN_MS * CPS_CLK_MHZ * 1000,
    parameter int RETRY_CYC     = CPS_RETRY_MS * CPS_CLK_MHZ * 1000,
    parameter int BOOST_DLY_CYC = CPS_BOOST_DLY_MS * CPS_CLK_MHZ * 1000
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [7:0]    paddr,
    input  wire logic [31:0]   pwdata,
    output logic               pready,
    output logic [31:0]        prdata,
    output logic               pslverr,
    input  wire cps_sense_type sense,
    input  wire logic          source_select_pin,
    input  wire logic [5:0]    bat_voltage_code,
    output cps_drive_type      drive,
    output logic [4:0]         eff_current_limit,
    output logic [4:0]         eff_voltage_limit,
    output logic               host_interrupt_pin_n
);

    cps_sense_type sense_meta;
    cps_sense_type s;
    cps_state_type state;
    logic [31:0]   timer;
    logic [31:0]   boost_timer;
    logic [31:0]   llm_timer;
    logic [7:0]    ctrl;
    logic [4:0]    input_current_limit_field;
    logic [3:0]    input_voltage_limit_field;
    logic [1:0]    battery_tracking_offset_field;
    logic          input_good_bit;
    logic          power_good_bit;
    logic [2:0]    source_type_field;
    logic          battery_switch_off_bit;
    logic [2:0]    irq_cnt;
    logic          irq_event;
    logic          irq_pend;
    logic          irq_start;
    logic          detect_done;
    logic          sel_d;
    logic          wr;
    logic          rd;
    logic [4:0]    next_icl;
    logic [4:0]    next_vlim;
    logic [6:0]    tracked;

    assign wr = psel && penable && pwrite;
    assign rd = psel && !penable && !pwrite;
    assign sel_d = source_select_pin;

    // Two-flop synchroniser on comparator outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sense_meta <= '0;
            s          <= '0;
        end else begin
            sense_meta <= sense;
            s          <= sense_meta;
        end
    end

    // Sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state       <= CPS_OFF;
            timer       <= '0;
            detect_done <= 1'b0;
        end else begin
            detect_done <= 1'b0;
            if (!s.input_present) begin
                state <= CPS_OFF;
                timer <= '0;
            end else begin
                case (state)
                    CPS_OFF: begin
                        timer <= '0;
                        if (s.above_sleep) begin
                            state <= CPS_BIAS_WAIT;
                        end
                    end
                    CPS_BIAS_WAIT: begin
                        if (!s.above_sleep) begin
                            state <= CPS_OFF;
                        end else if (timer >= 32'(BIAS_DLY_CYC - 1)) begin
                            state <= CPS_QUALIFY;
                            timer <= '0;
                        end else begin
                            timer <= timer + 32'h1;
                        end
                    end
                    CPS_QUALIFY: begin
                        if (!s.below_ovp || !s.above_min) begin
                            state <= CPS_RETRY;
                            timer <= '0;
                        end else if (timer >= 32'(QUAL_WIN_CYC - 1)) begin
                            state <= CPS_DETECT;
                            timer <= '0;
                        end else begin
                            timer <= timer + 32'h1;
                        end
                    end
                    CPS_RETRY: begin
                        if (timer >= 32'(RETRY_CYC - 1)) begin
                            state <= CPS_QUALIFY;
                            timer <= '0;
                        end else begin
                            timer <= timer + 32'h1;
                        end
                    end
                    CPS_DETECT: begin
                        if (!ctrl[CPS_CTRL_HOST_MODE] || ctrl[CPS_CTRL_DETECT_REQ]) begin
                            state       <= CPS_VLIMIT;
                            detect_done <= 1'b1;
                        end
                    end
                    CPS_VLIMIT: begin
                        state <= CPS_CONVERTER;
                    end
                    CPS_CONVERTER: begin
                        if (boost_timer >= 32'(BOOST_DLY_CYC) && s.bat_above_boost_low
                            && s.below_sleep && s.thermistor_ok) begin
                            state <= CPS_BOOST;
                        end
                    end
                    CPS_BOOST: begin
                        if (!ctrl[CPS_CTRL_BOOST_EN] || !s.bat_above_boost_low) begin
                            state <= CPS_CONVERTER;
                        end
                    end
                    default: state <= CPS_OFF;
                endcase
            end
        end
    end

    // Boost enable age counter, saturating
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            boost_timer <= '0;
        end else if (!ctrl[CPS_CTRL_BOOST_EN]) begin
            boost_timer <= '0;
        end else if (boost_timer < 32'(BOOST_DLY_CYC)) begin
            boost_timer <= boost_timer + 32'h1;
        end
    end

    // Light-load phase at boost entry
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            llm_timer <= '0;
        end else if (state != CPS_BOOST) begin
            llm_timer <= '0;
        end else if (llm_timer < 32'(CPS_LLM_CYC)) begin
            llm_timer <= llm_timer + 32'h1;
        end
    end

    // Status bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            input_good_bit    <= 1'b0;
            power_good_bit    <= 1'b0;
            source_type_field <= CPS_TYPE_NONE;
        end else if (state == CPS_OFF || !s.input_present) begin
            input_good_bit    <= 1'b0;
            power_good_bit    <= 1'b0;
            source_type_field <= CPS_TYPE_NONE;
        end else begin
            if (state == CPS_QUALIFY && s.below_ovp && s.above_min
                && timer >= 32'(QUAL_WIN_CYC - 1)) begin
                input_good_bit <= 1'b1;
            end
            if (detect_done) begin
                power_good_bit <= 1'b1;
            end
            if (state == CPS_BOOST) begin
                source_type_field <= CPS_TYPE_BOOST;
            end else if (detect_done || (power_good_bit && !ctrl[CPS_CTRL_HOST_MODE])) begin
                source_type_field <= sel_d ? CPS_TYPE_USB : CPS_TYPE_ADAPTER;
            end
        end
    end

    // Interrupt pulse stretcher, active low
    assign irq_event = detect_done || (state == CPS_QUALIFY && s.below_ovp && s.above_min
                       && timer >= 32'(QUAL_WIN_CYC - 1));
    // An event during a pulse waits for it to end, so the host never sees two merge
    assign irq_start = irq_cnt == 3'h0 && (irq_event || irq_pend);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_cnt              <= '0;
            irq_pend             <= 1'b0;
            host_interrupt_pin_n <= 1'b1;
        end else begin
            if (irq_start) begin
                irq_cnt <= 3'(CPS_IRQ_CYC);
            end else if (irq_cnt != 3'h0) begin
                irq_cnt <= irq_cnt - 3'h1;
            end
            irq_pend <= irq_start ? (irq_pend && irq_event) : (irq_pend || irq_event);
            host_interrupt_pin_n <= !(irq_start || irq_cnt > 3'h1);
        end
    end

    // Battery switch latch-off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            battery_switch_off_bit <= 1'b0;
        end else if (s.supplement && s.switch_overcurrent) begin
            battery_switch_off_bit <= 1'b1;
        end else if (s.input_present || (wr && paddr == CPS_OFS_CTRL
                     && pwdata[CPS_CTRL_SHIP_EXIT])) begin
            battery_switch_off_bit <= 1'b0;
        end else if (wr && paddr == CPS_OFS_CTRL) begin
            battery_switch_off_bit <= pwdata[CPS_CTRL_SWITCH_OFF];
        end
    end

    // Registers written by software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl                          <= CPS_CTRL_RESET;
            input_voltage_limit_field     <= CPS_VLIM_RESET;
            battery_tracking_offset_field <= CPS_TRACK_RESET;
        end else if (wr && paddr == CPS_OFS_CTRL) begin
            ctrl <= pwdata[7:0] & 8'h3F;
        end else if (wr && paddr == CPS_OFS_LIMIT) begin
            input_voltage_limit_field     <= pwdata[CPS_LIM_VLIM_LSB +: 4];
            battery_tracking_offset_field <= pwdata[CPS_LIM_TRACK_LSB +: 2];
        end else if (detect_done) begin
            ctrl[CPS_CTRL_DETECT_REQ] <= 1'b0;
        end
    end

    // Current limit field: detection wins over software write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            input_current_limit_field <= CPS_ICL_RESET;
        end else if (detect_done || (power_good_bit && !ctrl[CPS_CTRL_HOST_MODE])) begin
            input_current_limit_field <= sel_d ? CPS_ICL_500MA : CPS_ICL_2400MA;
        end else if (wr && paddr == CPS_OFS_LIMIT) begin
            input_current_limit_field <= pwdata[CPS_LIM_ICL_LSB +: 5];
        end
    end

    // Effective limits
    always_comb begin
        next_icl = input_current_limit_field;
        if (s.sys_below_2v2 && input_current_limit_field > CPS_ICL_200MA) begin
            next_icl = CPS_ICL_200MA;
        end
        // Extra bit so a high battery code cannot wrap below the limit
        tracked   = {1'b0, bat_voltage_code}
                    + {2'b00, cps_track_code(battery_tracking_offset_field)};
        next_vlim = {1'b0, input_voltage_limit_field};
        if (battery_tracking_offset_field != CPS_TRACK_OFF
            && tracked > {3'b000, input_voltage_limit_field}) begin
            next_vlim = (tracked > 7'h1F) ? 5'h1F : tracked[4:0];
        end
    end

    // Power stage drive
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drive             <= '0;
            eff_current_limit <= CPS_ICL_RESET;
            eff_voltage_limit <= {1'b0, CPS_VLIM_RESET};
        end else begin
            eff_current_limit <= next_icl;
            eff_voltage_limit <= next_vlim;
            drive.bias_regulator_en        <= state != CPS_OFF && state != CPS_BIAS_WAIT;
            drive.input_blocking_switch_on <= state != CPS_OFF && state != CPS_BIAS_WAIT;
            drive.qual_load_on             <= state == CPS_QUALIFY;
            drive.converter_en             <= state == CPS_CONVERTER || state == CPS_BOOST;
            drive.soft_start               <= state == CPS_CONVERTER && s.sys_below_2v2;
            drive.boost_mode               <= state == CPS_BOOST;
            drive.boost_pwm                <= state == CPS_BOOST
                                              && llm_timer >= 32'(CPS_LLM_CYC);
            drive.boost_high_limit         <= !ctrl[CPS_CTRL_BOOST_CURRENT_LIMIT_BIT];
            drive.light_load_ok <= !ctrl[CPS_CTRL_LLM_BLOCK] && (state == CPS_BOOST
                ? llm_timer < 32'(CPS_LLM_CYC)
                : (!ctrl[CPS_CTRL_CHARGE_EN] || s.bat_below_minsys));
            if (battery_switch_off_bit || (s.supplement && s.switch_overcurrent)) begin
                drive.battery_switch_on <= 1'b0;
            end else if (state == CPS_CONVERTER) begin
                drive.battery_switch_on <= ctrl[CPS_CTRL_CHARGE_EN];
            end else if (!s.input_present) begin
                drive.battery_switch_on <= s.bat_above_depl;
            end else begin
                drive.battery_switch_on <= 1'b1;
            end
        end
    end

    // APB read path, zero wait states
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= '0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && paddr != CPS_OFS_CTRL && paddr != CPS_OFS_LIMIT
                       && paddr != CPS_OFS_STATUS && paddr != CPS_OFS_EFF;
            if (rd) begin
                case (paddr)
                    CPS_OFS_CTRL:   prdata <= {24'h0, ctrl[7], battery_switch_off_bit, ctrl[5:0]};
                    CPS_OFS_LIMIT:  prdata <= {18'h0, battery_tracking_offset_field,
                                               input_voltage_limit_field, 3'h0,
                                               input_current_limit_field};
                    CPS_OFS_STATUS: prdata <= {21'h0, 3'(state), 3'h0, source_type_field,
                                               power_good_bit, input_good_bit};
                    CPS_OFS_EFF:    prdata <= {19'h0, eff_voltage_limit, 3'h0, eff_current_limit};
                    default:        prdata <= 32'h0;
                endcase
            end
        end
    end

    // A qualify pass always moves on to detection
    property p_qual_pass;
        @(posedge pclk) disable iff (!presetn)
        (state == CPS_QUALIFY && s.input_present && s.below_ovp && s.above_min
         && timer >= 32'(QUAL_WIN_CYC - 1)) |=> input_good_bit && state == CPS_DETECT;
    endproperty
    a_qual_pass: assert property (p_qual_pass) else $error("qualify pass lost");

    sequence s_irq_evt;
        irq_start;
    endsequence
    property p_irq_low;
        @(posedge pclk) disable iff (!presetn)
        s_irq_evt |=> !host_interrupt_pin_n [*4] ##1 host_interrupt_pin_n;
    endproperty
    a_irq_low: assert property (p_irq_low) else $error("interrupt pulse short");

    property p_boost_type;
        @(posedge pclk) disable iff (!presetn)
        (state == CPS_BOOST && s.input_present) |=> source_type_field == CPS_TYPE_BOOST;
    endproperty
    a_boost_type: assert property (p_boost_type) else $error("boost type wrong");

    property p_ocp_off;
        @(posedge pclk) disable iff (!presetn)
        (s.supplement && s.switch_overcurrent) |=> !drive.battery_switch_on
                                                   && battery_switch_off_bit;
    endproperty
    a_ocp_off: assert property (p_ocp_off) else $error("overcurrent ignored");

    property p_bias_order;
        @(posedge pclk) disable iff (!presetn)
        $rose(drive.converter_en) |-> power_good_bit;
    endproperty
    a_bias_order: assert property (p_bias_order) else $error("converter early");

    property p_bias_wait;
        @(posedge pclk) disable iff (!presetn)
        (state == CPS_BIAS_WAIT) |=> !drive.bias_regulator_en;
    endproperty
    a_bias_wait: assert property (p_bias_wait) else $error("bias early");

    property p_boost_gate;
        @(posedge pclk) disable iff (!presetn)
        $rose(state == CPS_BOOST) |-> $past(boost_timer) >= 32'(BOOST_DLY_CYC)
                                      && $past(ctrl[CPS_CTRL_BOOST_EN]);
    endproperty
    a_boost_gate: assert property (p_boost_gate) else $error("boost early");

    property p_low_rail;
        @(posedge pclk) disable iff (!presetn)
        (s.sys_below_2v2 && input_current_limit_field > CPS_ICL_200MA) |=>
            eff_current_limit == CPS_ICL_200MA;
    endproperty
    a_low_rail: assert property (p_low_rail) else $error("rail clamp missing");

endmodule // cps_sequencer

// ===== verilog/cps_pkg.sv
// Package with constants and carrier types for the charger power-up sequencer
package cps_pkg;

    // APB register byte offsets
    localparam logic [7:0] CPS_OFS_CTRL   = 8'h00;
    localparam logic [7:0] CPS_OFS_LIMIT  = 8'h04;
    localparam logic [7:0] CPS_OFS_STATUS = 8'h08;
    localparam logic [7:0] CPS_OFS_EFF    = 8'h0C;

    // Control register fields
    localparam int CPS_CTRL_HOST_MODE   = 0;
    localparam int CPS_CTRL_DETECT_REQ  = 1;
    localparam int CPS_CTRL_CHARGE_EN   = 2;
    localparam int CPS_CTRL_LLM_BLOCK   = 3;
    localparam int CPS_CTRL_BOOST_EN    = 4;
    localparam int CPS_CTRL_BOOST_CURRENT_LIMIT_BIT   = 5;
    localparam int CPS_CTRL_SWITCH_OFF  = 6;
    localparam int CPS_CTRL_SHIP_EXIT   = 7;

    // Limit register fields
    localparam int CPS_LIM_ICL_LSB      = 0;
    localparam int CPS_LIM_VLIM_LSB     = 8;
    localparam int CPS_LIM_TRACK_LSB    = 12;

    // Status register fields
    localparam int CPS_ST_INPUT_GOOD    = 0;
    localparam int CPS_ST_POWER_GOOD    = 1;
    localparam int CPS_ST_TYPE_LSB      = 2;
    localparam int CPS_ST_STATE_LSB     = 8;

    // Codes and reset values: ICL code n = 100 mA * (n + 1); VLIM code n = 3.9 V + 0.1 V * n
    localparam logic [4:0] CPS_ICL_RESET    = 5'h04;
    localparam logic [4:0] CPS_ICL_500MA    = 5'h04;
    localparam logic [4:0] CPS_ICL_2400MA   = 5'h17;
    localparam logic [4:0] CPS_ICL_200MA    = 5'h01;
    localparam logic [3:0] CPS_VLIM_RESET   = 4'h6;
    localparam logic [1:0] CPS_TRACK_RESET  = 2'h0;
    localparam logic [1:0] CPS_TRACK_OFF    = 2'h0;
    localparam logic [2:0] CPS_TYPE_NONE    = 3'h0;
    localparam logic [2:0] CPS_TYPE_USB     = 3'h1;
    localparam logic [2:0] CPS_TYPE_ADAPTER = 3'h2;
    localparam logic [2:0] CPS_TYPE_BOOST   = 3'h7;
    localparam logic [7:0] CPS_CTRL_RESET   = 8'h04;

    // Timing
    localparam int CPS_CLK_MHZ       = 250;
    localparam int CPS_BIAS_DLY_MS   = 220;
    localparam int CPS_QUAL_WIN_MS   = 30;
    localparam int CPS_RETRY_MS      = 2000;
    localparam int CPS_BOOST_DLY_MS  = 30;
    localparam int CPS_LLM_US        = 10;
    localparam int CPS_LLM_CYC       = CPS_LLM_US * CPS_CLK_MHZ;
    localparam int CPS_IRQ_CYC       = 4;

    typedef enum {
        CPS_OFF, CPS_BIAS_WAIT, CPS_QUALIFY, CPS_RETRY, CPS_DETECT,
        CPS_VLIMIT, CPS_CONVERTER, CPS_BOOST
    } cps_state_type;

    // Analog comparator indications
    typedef struct packed {
        logic input_present;
        logic above_sleep;
        logic below_sleep;
        logic below_ovp;
        logic above_min;
        logic bat_above_depl;
        logic bat_above_boost_low;
        logic bat_below_minsys;
        logic thermistor_ok;
        logic switch_overcurrent;
        logic sys_below_2v2;
        logic supplement;
    } cps_sense_type;

    // Power stage controls
    typedef struct packed {
        logic bias_regulator_en;
        logic input_blocking_switch_on;
        logic qual_load_on;
        logic battery_switch_on;
        logic converter_en;
        logic soft_start;
        logic boost_mode;
        logic light_load_ok;
        logic boost_pwm;
        logic boost_high_limit;
    } cps_drive_type;

    // Read voltage code: (bat mV + offset) vs limit, compare in 100 mV units
    function automatic logic [4:0] cps_track_code(input logic [1:0] sel);
        case (sel)
            2'h1:    cps_track_code = 5'h02;
            2'h2:    cps_track_code = 5'h03;
            2'h3:    cps_track_code = 5'h03;
            default: cps_track_code = 5'h00;
        endcase
    endfunction

endpackage

// ===== tb/cps_host_model.sv
// Host side model: counts interrupt pulses seen on the pin
`timescale 1ns/100ps
module cps_host_model (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic host_interrupt_pin_n,
    output int        pulses
);
    logic last;
    // Counted at release so a stuck-low pin is never taken as events
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last   <= 1'h1;
            pulses <= 0;
        end else begin
            last <= host_interrupt_pin_n;
            if (host_interrupt_pin_n && !last) pulses <= pulses + 1;
        end
    end
endmodule // cps_host_model

// ===== tb/testbench.sv
// Self-checking bench for the charger power-up sequencer
`timescale 1ns/100ps
module testbench;
    import cps_pkg::*;
    typedef struct {logic [7:0] a; logic [31:0] d; logic e;} cps_row_type;
    logic          pclk, presetn, psel, penable, pwrite, pready, pslverr, sel_pin, irq_n;
    logic [7:0]    paddr;
    logic [31:0]   pwdata, prdata, rd;
    logic          er;
    cps_sense_type sense;
    cps_drive_type drive;
    logic [4:0]    eff_i, eff_v;
    logic [5:0]    bat_code;
    int            n_errors, check_count, cyc, pulses;
    cps_row_type   rows [5] = '{'{8'h00, 32'h4, 1'h0}, '{8'h04, 32'h604, 1'h0},
                                '{8'h08, 32'h0, 1'h0}, '{8'h0C, 32'h604, 1'h0},
                                '{8'h10, 32'h0, 1'h1}};
    cps_sequencer #(.BIAS_DLY_CYC(20), .QUAL_WIN_CYC(20), .RETRY_CYC(20),
        .BOOST_DLY_CYC(20)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .sense(sense),
        .source_select_pin(sel_pin), .bat_voltage_code(bat_code), .drive(drive),
        .eff_current_limit(eff_i), .eff_voltage_limit(eff_v),
        .host_interrupt_pin_n(irq_n));
    cps_host_model host (.pclk(pclk), .presetn(presetn), .host_interrupt_pin_n(irq_n),
        .pulses(pulses));
    initial begin
        pclk = 1'h0;
        forever #2 pclk = ~pclk;
    end
    task automatic tally_and_finish();
        if (n_errors == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Cuts a hang well past the longest wait of the sequence
    always @(posedge pclk) begin
        cyc++;
        if (cyc > 5000) begin
            n_errors++;
            tally_and_finish();
        end
    end
    task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1; penable <= 1'h0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0; penable <= 1'h0;
    endtask
    task automatic wt(int n);
        repeat (n) @(posedge pclk);
    endtask
    initial begin
        presetn = 1'h0; psel = 1'h0; penable = 1'h0; pwrite = 1'h0;
        paddr = 8'h00; pwdata = 32'h0; sense = '0; sel_pin = 1'h1;
        bat_code = 6'h06;
        wt(2);
        chk("eff_i", 32'h04, 32'(eff_i));
        chk("eff_v", 32'h06, 32'(eff_v));
        chk("irq_n", 32'h1, 32'(irq_n));
        presetn <= 1'h1;
        foreach (rows[i]) begin
            apb(1'h0, rows[i].a, 32'h0);
            chk("rdata", rows[i].d, rd);
            chk("slverr", 32'(rows[i].e), 32'(er));
        end
        sense.bat_above_depl <= 1'h1;
        wt(5);
        chk("bat_sw", 32'h1, 32'(drive.battery_switch_on));
        chk("bias", 32'h0, 32'(drive.bias_regulator_en));
        sense.supplement <= 1'h1; sense.switch_overcurrent <= 1'h1;
        wt(5);
        chk("bat_sw", 32'h0, 32'(drive.battery_switch_on));
        apb(1'h0, CPS_OFS_CTRL, 32'h0);
        chk("off_bit", 32'h1, 32'(rd[CPS_CTRL_SWITCH_OFF]));
        sense.switch_overcurrent <= 1'h0; sense.supplement <= 1'h0;
        wt(5);
        chk("bat_sw", 32'h0, 32'(drive.battery_switch_on));
        sense.input_present <= 1'h1; sense.above_sleep <= 1'h1;
        sense.below_ovp <= 1'h1; sense.above_min <= 1'h1;
        for (int i = 0; i < 400 && drive.converter_en !== 1'h1; i++) @(posedge pclk);
        wt(10);
        chk("conv", 32'h1, 32'(drive.converter_en));
        chk("bat_sw", 32'h1, 32'(drive.battery_switch_on));
        chk("pulses", 32'h2, 32'(pulses));
        apb(1'h0, CPS_OFS_STATUS, 32'h0);
        chk("status", 32'h07, 32'(rd[4:0]));
        chk("eff_i", 32'(CPS_ICL_500MA), 32'(eff_i));
        sel_pin <= 1'h0;
        wt(6);
        chk("eff_i", 32'(CPS_ICL_2400MA), 32'(eff_i));
        sense.sys_below_2v2 <= 1'h1;
        wt(6);
        chk("eff_i", 32'(CPS_ICL_200MA), 32'(eff_i));
        chk("llm", 32'h0, 32'(drive.light_load_ok));
        apb(1'h1, CPS_OFS_LIMIT, 32'h1600);
        wt(3);
        chk("eff_v", 32'h08, 32'(eff_v));
        bat_code <= 6'h3F;
        wt(3);
        chk("eff_v", 32'h1F, 32'(eff_v));
        bat_code <= 6'h02;
        wt(3);
        chk("eff_v", 32'h06, 32'(eff_v));
        apb(1'h1, CPS_OFS_CTRL, 32'h0);
        wt(4);
        chk("bat_sw", 32'h0, 32'(drive.battery_switch_on));
        chk("llm", 32'h1, 32'(drive.light_load_ok));
        sense.bat_above_boost_low <= 1'h1;
        sense.below_sleep <= 1'h1;
        sense.thermistor_ok <= 1'h1;
        apb(1'h1, CPS_OFS_CTRL, 32'h10);
        wt(10);
        chk("boost", 32'h0, 32'(drive.boost_mode));
        wt(20);
        chk("boost", 32'h1, 32'(drive.boost_mode));
        chk("b_lim", 32'h1, 32'(drive.boost_high_limit));
        chk("b_pwm", 32'h0, 32'(drive.boost_pwm));
        chk("llm", 32'h1, 32'(drive.light_load_ok));
        apb(1'h0, CPS_OFS_STATUS, 32'h0);
        chk("type", 32'h7, 32'(rd[4:2]));
        wt(CPS_LLM_CYC);
        chk("b_pwm", 32'h1, 32'(drive.boost_pwm));
        chk("llm", 32'h0, 32'(drive.light_load_ok));
        apb(1'h1, CPS_OFS_CTRL, 32'h30);
        wt(2);
        chk("b_lim", 32'h0, 32'(drive.boost_high_limit));
        // Mid-run reset, then a failing source and a host-mode detection
        presetn <= 1'h0;
        sense.below_ovp <= 1'h0;
        wt(2);
        chk("drive", 32'h0, 32'(drive));
        chk("irq_n", 32'h1, 32'(irq_n));
        chk("eff_i", 32'(CPS_ICL_RESET), 32'(eff_i));
        presetn <= 1'h1;
        apb(1'h1, CPS_OFS_CTRL, 32'h5);
        wt(60);
        chk("bias", 32'h1, 32'(drive.bias_regulator_en));
        chk("conv", 32'h0, 32'(drive.converter_en));
        sense.below_ovp <= 1'h1;
        wt(80);
        apb(1'h0, CPS_OFS_STATUS, 32'h0);
        chk("status", 32'h1, 32'(rd[1:0]));
        chk("conv", 32'h0, 32'(drive.converter_en));
        apb(1'h1, CPS_OFS_CTRL, 32'h7);
        wt(10);
        chk("conv", 32'h1, 32'(drive.converter_en));
        apb(1'h0, CPS_OFS_CTRL, 32'h0);
        chk("ctrl", 32'h5, rd);
        tally_and_finish();
    end
endmodule // testbench
